//--- core/fprml_motion.sv
`timescale 1ns/1ps
module fprml_motion
   import fprml_pkg::*;
#(
   parameter int SW = SAMPLE_W,
   parameter int LW = LEVEL_W,
   parameter int PW = PERSIST_W
) (
   input  wire logic                 clk_sys,
   input  wire logic                 sys_rst,
   input  wire logic                 clear,
   input  wire logic                 sampleValid,
   input  wire logic [3*SW-1:0]      sampleXyz,
   input  wire logic [LW-1:0]        motionTriggerLevel,
   input  wire logic [PW-1:0]        motionPersistCount,
   output logic                      motionEvent_q
);
   typedef struct packed {
      logic [PW-1:0] run;
      logic          event_;
   } fprml_mot_t;

   fprml_mot_t st_q;
   fprml_mot_t st_d;
   logic [2:0] over;

   // R10 - magnitude versus level
   // R12 - raw codes, unscaled
   generate
      for (genvar a = 0; a < 3; a++) begin : g_axis
         logic signed [SW-1:0] s;
         logic [SW-1:0]        mag;
         assign s    = sampleXyz[a*SW +: SW];
         assign mag  = s[SW-1] ? SW'(-s) : SW'(s);
         assign over[a] = mag > {1'b0, motionTriggerLevel};
      end
   endgenerate

   always_comb begin
      st_d        = st_q;
      st_d.event_ = 1'b0;
      if (sampleValid) begin
         // R13 - consecutive sample persistence
         if (|over) begin
            if (st_q.run + PW'(1) >= motionPersistCount) begin
               st_d.event_ = 1'b1;
               st_d.run    = st_q.run;
            end else begin
               st_d.run = st_q.run + PW'(1);
            end
         end else begin
            st_d.run = '0;
         end
      end
      if (clear) begin
         st_d = '0;
      end
   end

   always_ff @(posedge clk_sys) begin
      if (sys_rst) begin
         st_q <= '0;
      end else begin
         st_q <= st_d;
      end
   end

   assign motionEvent_q = st_q.event_;
endmodule // fprml_motion

//--- core/fprml_pkg.sv
package fprml_pkg;
   localparam int          REG_AW          = 8;
   localparam int          REG_DW          = 8;
   localparam int          WORD_W          = 16;
   localparam int          SAMPLE_W        = 14;
   localparam int          LEVEL_W         = 13;
   localparam int          PERSIST_W       = 8;
   // Register byte addresses
   localparam logic [7:0]  ADDR_FIFO_POP   = 8'h18;
   localparam logic [7:0]  ADDR_RESET_KEY  = 8'h1F;
   localparam logic [7:0]  ADDR_LVL_UPPER  = 8'h20;
   localparam logic [7:0]  ADDR_LVL_LOWER  = 8'h21;
   // Key and reset values
   localparam logic [7:0]  RESET_KEY_CODE  = 8'h52;
   localparam logic [7:0]  RST_FIFO_POP    = 8'h00;
   localparam logic [7:0]  RST_RESET_KEY   = 8'h52;
   localparam logic [6:0]  RST_LVL_UPPER   = 7'h00;
   localparam logic [5:0]  RST_LVL_LOWER   = 6'h00;
   localparam logic [7:0]  READ_ZERO       = 8'h00;
   // Field positions of the split trigger level
   localparam int          LVL_UPPER_MSB   = 6;
   localparam int          LVL_UPPER_LSB   = 0;
   localparam int          LVL_LOWER_MSB   = 7;
   localparam int          LVL_LOWER_LSB   = 2;
   localparam int          LVL_UPPER_BITS  = 7;
   localparam int          LVL_LOWER_BITS  = 6;
   // Host wait after the reset key, kept for reference by the host side
   localparam int          CLK_PERIOD_PS   = 5000;
   localparam int          SOFT_RST_WAIT_NS = 500000;
   localparam int          SOFT_RST_WAIT_CYC = (SOFT_RST_WAIT_NS * 1000) / CLK_PERIOD_PS;
endpackage

//--- core/fprml_regs.sv
// Function
// R1 - FIFO port read pops one word
// R2 - Word delivered as two bytes
// R3 - Continued port reads keep popping
// R4 - Pointer holds at FIFO port
// R5 - Auto-increment skips port, no pop
// R6 - Key write resets whole device
// R7 - Interrupt pins float after reset
// R8 - Reset register reads zero
// R9 - Host waits half millisecond after reset
// R10 - Compare sample magnitude to level
// R11 - Level split over two registers
// R12 - Level in raw codes
// R13 - Persistent samples raise activity
// R14 - Reserved bits zero, writes ignored
// R15 - Pointer auto-increments elsewhere
`timescale 1ns/1ps
module fprml_regs
   import fprml_pkg::*;
#(
   parameter int WW = WORD_W,
   parameter int SW = SAMPLE_W
) (
   input  wire logic                 clk_sys,
   input  wire logic                 sys_rst,
   // Host register port
   input  wire logic                 addrLoad,
   input  wire logic [REG_AW-1:0]    addrIn,
   input  wire logic                 byteRd,
   input  wire logic                 byteWr,
   input  wire logic [REG_DW-1:0]    wrData,
   input  wire logic [REG_DW-1:0]    extRdData,
   // Sample FIFO and motion path
   input  wire logic [WW-1:0]        fifoHead,
   input  wire logic                 intRouteActive,
   input  wire logic                 sampleValid,
   input  wire logic [3*SW-1:0]      sampleXyz,
   input  wire logic [PERSIST_W-1:0] motionPersistCount,
   // Answers and device controls
   output logic [REG_DW-1:0]         rdData_q,
   output logic                      rdValid_q,
   output logic                      fifoPop_q,
   output logic                      devSoftRst_q,
   output logic                      intDriveEn_q,
   output logic                      motionEvent_q
);
   // Whole state of the slice but the motion path in one record
   typedef struct packed {
      logic [REG_AW-1:0]         ptr;
      logic                      lowPending;
      logic [WW-1:0]             word;
      logic [REG_DW-1:0]         rdData;
      logic                      rdValid;
      logic                      pop;
      logic                      softRst;
      logic                      intEn;
      logic [LVL_UPPER_BITS-1:0] lvlUpper;
      logic [LVL_LOWER_BITS-1:0] lvlLower;
   } fprml_regs_t;

   fprml_regs_t           st_q;
   fprml_regs_t           st_d;
   logic [LEVEL_W-1:0]    level;
   logic [REG_AW-1:0]     nextPtr;
   logic                  hitFifo;
   logic                  hitKey;
   logic                  hitUpper;
   logic                  hitLower;
   logic                  keyMatch;
   logic                  keyWrite;
   logic                  intEnNext;
   logic [REG_DW-1:0]     sliceByte;
   logic [REG_DW-1:0]     rdByte;

   // R11 - level assembly
   assign level = {st_q.lvlUpper, st_q.lvlLower};

   // One decoder for the pointer keeps read and write paths in step
   always_comb begin
      hitFifo  = 1'b0;
      hitKey   = 1'b0;
      hitUpper = 1'b0;
      hitLower = 1'b0;
      if (st_q.ptr == ADDR_FIFO_POP) begin
         hitFifo = 1'b1;
      end else if (st_q.ptr == ADDR_RESET_KEY) begin
         hitKey = 1'b1;
      end else if (st_q.ptr == ADDR_LVL_UPPER) begin
         hitUpper = 1'b1;
      end else if (st_q.ptr == ADDR_LVL_LOWER) begin
         hitLower = 1'b1;
      end
   end

   // R6 - key code match
   assign keyMatch = hitKey && (wrData == RESET_KEY_CODE);
   assign keyWrite = byteWr && !byteRd && !addrLoad && keyMatch;

   // Registers outside this slice answer through extRdData
   always_comb begin
      sliceByte = extRdData;
      if (hitKey) begin
         // R8 - write-only register
         sliceByte = READ_ZERO;
      end else if (hitUpper) begin
         // R14 - reserved reads zero
         sliceByte = {1'b0, st_q.lvlUpper};
      end else if (hitLower) begin
         sliceByte = {st_q.lvlLower, 2'b00};
      end
   end

   // The low byte comes from the captured word, so a FIFO move
   // between the two reads cannot tear an axis sample
   always_comb begin
      rdByte = sliceByte;
      if (hitFifo) begin
         if (st_q.lowPending) begin
            // R2 - second byte read
            rdByte = st_q.word[REG_DW-1:0];
         end else begin
            rdByte = fifoHead[WW-1 -: REG_DW];
         end
      end
   end

   // Held low in the key cycle and the next, so the pins stay released
   // while the rest of the device restarts
   always_comb begin
      intEnNext = intRouteActive;
      // R7 - release interrupt drive
      if (st_q.softRst || keyWrite) begin
         intEnNext = 1'b0;
      end
   end

   // Pointer step for every byte read or written
   always_comb begin
      nextPtr = st_q.ptr;
      // R4 - hold at port
      if (st_q.ptr != ADDR_FIFO_POP) begin
         nextPtr = st_q.ptr + REG_AW'(1);
         // R5 - skip port increment
         if (nextPtr == ADDR_FIFO_POP) begin
            nextPtr = ADDR_FIFO_POP + REG_AW'(1);
         end
      end
   end

   always_comb begin
      st_d         = st_q;
      st_d.rdValid = 1'b0;
      st_d.pop     = 1'b0;
      st_d.softRst = 1'b0;
      st_d.intEn   = intEnNext;
      if (addrLoad) begin
         st_d.ptr        = addrIn;
         st_d.lowPending = 1'b0;
      end else if (byteRd) begin
         // R15 - pointer auto-increment
         st_d.ptr     = nextPtr;
         st_d.rdValid = 1'b1;
         st_d.rdData  = rdByte;
         if (hitFifo) begin
            // R1 - pop on read
            // R3 - repeated pops
            st_d.pop        = !st_q.lowPending;
            st_d.lowPending = !st_q.lowPending;
            if (!st_q.lowPending) begin
               st_d.word = fifoHead;
            end
         end
      end else if (byteWr) begin
         st_d.ptr = nextPtr;
         if (hitUpper) begin
            // R14 - reserved writes dropped
            st_d.lvlUpper = wrData[LVL_UPPER_MSB:LVL_UPPER_LSB];
         end else if (hitLower) begin
            st_d.lvlLower = wrData[LVL_LOWER_MSB:LVL_LOWER_LSB];
         end else if (keyMatch) begin
            // R6 - keyed device reset
            st_d.softRst    = 1'b1;
            st_d.lvlUpper   = RST_LVL_UPPER;
            st_d.lvlLower   = RST_LVL_LOWER;
            st_d.lowPending = 1'b0;
         end
      end
   end

   // Pin reset only; the key reset acts through the next-state logic
   always_ff @(posedge clk_sys) begin
      if (sys_rst) begin
         st_q          <= '0;
         st_q.rdData   <= RST_FIFO_POP;
         st_q.lvlUpper <= RST_LVL_UPPER;
         st_q.lvlLower <= RST_LVL_LOWER;
      end else begin
         st_q <= st_d;
      end
   end

   // Outputs other than motionEvent_q come straight from the state record
   assign rdData_q     = st_q.rdData;
   assign rdValid_q    = st_q.rdValid;
   assign fifoPop_q    = st_q.pop;
   assign devSoftRst_q = st_q.softRst;
   assign intDriveEn_q = st_q.intEn;

   // R10 - activity compare
   fprml_motion #(
      .SW (SW),
      .LW (LEVEL_W),
      .PW (PERSIST_W)
   ) u_motion (
      .clk_sys            (clk_sys),
      .sys_rst            (sys_rst),
      .clear              (st_q.softRst),
      .sampleValid        (sampleValid),
      .sampleXyz          (sampleXyz),
      .motionTriggerLevel (level),
      .motionPersistCount (motionPersistCount),
      .motionEvent_q      (motionEvent_q)
   );
endmodule // fprml_regs

//--- dv/fprml_fifo_model.sv
`timescale 1ns/1ps
module fprml_fifo_model (
   input  wire logic        clk_sys,
   input  wire logic        sys_rst,
   input  wire logic        fifoPop_q,
   output logic      [15:0] fifoHead
);
   // Step of 0x1111 keeps every byte distinct, so a swapped byte shows
   always_ff @(posedge clk_sys) begin
      if (sys_rst)
         fifoHead <= 16'hA15C;
      else if (fifoPop_q)
         fifoHead <= fifoHead + 16'h1111;
   end
endmodule // fprml_fifo_model

//--- dv/fprml_regs_asserts.sv
`timescale 1ns/1ps
module fprml_regs_asserts (
   input wire logic       clk_sys,
   input wire logic       sys_rst,
   input wire logic       addrLoad,
   input wire logic       byteRd,
   input wire logic       byteWr,
   input wire logic [7:0] wrData,
   input wire logic       intRouteActive,
   input wire logic       sampleValid,
   input wire logic       rdValid_q,
   input wire logic       fifoPop_q,
   input wire logic       devSoftRst_q,
   input wire logic       intDriveEn_q,
   input wire logic       motionEvent_q
);
   default clocking @(posedge clk_sys); endclocking
   default disable iff (sys_rst);
   read_answer_a: assert property (byteRd && !addrLoad |=> rdValid_q)
      else $error("read lost");
   valid_cause_a: assert property (rdValid_q |-> $past(byteRd && !addrLoad))
      else $error("stray read");
   pop_on_read_a: assert property (fifoPop_q |-> rdValid_q && $past(byteRd))
      else $error("stray pop");
   pop_pair_a: assert property (fifoPop_q |=> !fifoPop_q)
      else $error("low byte popped");
   key_cause_a: assert property (devSoftRst_q |-> $past(byteWr && !byteRd && !addrLoad
      && wrData == 8'h52))
      else $error("reset without key");
   pins_float_a: assert property (devSoftRst_q |-> !intDriveEn_q ##1 !intDriveEn_q)
      else $error("pins driven");
   pins_follow_a: assert property (!$past(sys_rst) && !devSoftRst_q && !$past(devSoftRst_q)
      |-> intDriveEn_q == $past(intRouteActive))
      else $error("enable wrong");
   event_cause_a: assert property (motionEvent_q |-> $past(sampleValid))
      else $error("stray event");
endmodule // fprml_regs_asserts

//--- dv/testbench.sv
`timescale 1ns/1ps
`define CHK(a, b) begin checksDone++; if ((a) !== (b)) begin failures++; \
   $display("wrong value t=%0t got %h exp %h", $time, a, b); end end
module testbench;
   import fprml_pkg::*;
   logic        clk_sys = 1'h0;
   logic        sys_rst = 1'h1;
   logic        addrLoad = 1'h0, byteRd = 1'h0, byteWr = 1'h0, sampleValid = 1'h0;
   logic [7:0]  addrIn = 8'h00, wrData = 8'h00, rdData_q;
   logic [41:0] sampleXyz = 42'h0;
   logic [15:0] fifoHead;
   logic        intRouteActive = 1'h1;
   logic [7:0]  motionPersistCount = 8'h02;
   logic        rdValid_q, fifoPop_q, devSoftRst_q, intDriveEn_q, motionEvent_q;
   int          failures = 0;
   int          checksDone = 0;
   always #2.5 clk_sys = ~clk_sys;
   fprml_regs fprml_regs_i (
      .clk_sys            (clk_sys),
      .sys_rst            (sys_rst),
      .addrLoad           (addrLoad),
      .addrIn             (addrIn),
      .byteRd             (byteRd),
      .byteWr             (byteWr),
      .wrData             (wrData),
      .extRdData          (8'h3C),
      .fifoHead           (fifoHead),
      .intRouteActive     (intRouteActive),
      .sampleValid        (sampleValid),
      .sampleXyz          (sampleXyz),
      .motionPersistCount (motionPersistCount),
      .rdData_q           (rdData_q),
      .rdValid_q          (rdValid_q),
      .fifoPop_q          (fifoPop_q),
      .devSoftRst_q       (devSoftRst_q),
      .intDriveEn_q       (intDriveEn_q),
      .motionEvent_q      (motionEvent_q)
   );
   fprml_fifo_model fprml_fifo_model_i (
      .clk_sys   (clk_sys),
      .sys_rst   (sys_rst),
      .fifoPop_q (fifoPop_q),
      .fifoHead  (fifoHead)
   );
   task automatic ld(input logic [7:0] a);
      @(posedge clk_sys);
      addrLoad <= 1'h1;
      addrIn <= a;
      @(posedge clk_sys);
      addrLoad <= 1'h0;
   endtask
   task automatic rd(input logic [7:0] e, input logic p);
      @(posedge clk_sys);
      byteRd <= 1'h1;
      @(posedge clk_sys);
      byteRd <= 1'h0;
      #1 `CHK({rdValid_q, fifoPop_q, rdData_q}, {1'h1, p, e})
   endtask
   task automatic burst(input logic [15:0] e);
      @(posedge clk_sys);
      byteRd <= 1'h1;
      @(posedge clk_sys);
      #1 `CHK({rdValid_q, fifoPop_q, rdData_q}, {2'h3, e[15:8]})
      @(posedge clk_sys);
      byteRd <= 1'h0;
      #1 `CHK({rdValid_q, fifoPop_q, rdData_q}, {2'h2, e[7:0]})
   endtask
   task automatic wr(input logic [7:0] d, input logic k);
      @(posedge clk_sys);
      byteWr <= 1'h1;
      wrData <= d;
      @(posedge clk_sys);
      byteWr <= 1'h0;
      #1 `CHK({devSoftRst_q, intDriveEn_q}, {k, !k})
   endtask
   task automatic smp(input logic [41:0] v, input logic e);
      @(posedge clk_sys);
      sampleValid <= 1'h1;
      sampleXyz <= v;
      @(posedge clk_sys);
      sampleValid <= 1'h0;
      #1 `CHK(motionEvent_q, e)
   endtask
   task automatic complete_run();
      if (failures == 0 && checksDone > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask
   initial begin
      repeat (3) @(posedge clk_sys);
      sys_rst <= 1'h0;
      ld(ADDR_FIFO_POP);
      rd(8'hA1, 1'h1);
      rd(8'h5C, 1'h0);
      rd(8'hB2, 1'h1);
      rd(8'h6D, 1'h0);
      burst(16'hC37E);
      burst(16'hD48F);
      ld(8'h17);
      rd(8'h3C, 1'h0);
      rd(8'h3C, 1'h0);
      ld(ADDR_RESET_KEY);
      wr(8'h51, 1'h0);
      ld(ADDR_RESET_KEY);
      rd(8'h00, 1'h0);
      rd(8'h00, 1'h0);
      ld(ADDR_LVL_UPPER);
      wr(8'h80, 1'h0);
      wr(8'h0F, 1'h0);
      ld(ADDR_LVL_UPPER);
      rd(8'h00, 1'h0);
      rd(8'h0C, 1'h0);
      // Level is now 3 codes, persistence 2 samples
      smp({14'h0000, 14'h3FFC, 14'h0000}, 1'h0);
      smp({14'h0000, 14'h3FFC, 14'h0000}, 1'h1);
      smp({14'h0000, 14'h0000, 14'h0003}, 1'h0);
      smp({14'h0004, 14'h0000, 14'h0000}, 1'h0);
      @(posedge clk_sys);
      motionPersistCount <= 8'h00;
      smp({14'h0000, 14'h0000, 14'h0000}, 1'h0);
      smp({14'h0004, 14'h0000, 14'h0000}, 1'h1);
      @(posedge clk_sys);
      intRouteActive <= 1'h0;
      @(posedge clk_sys);
      #1 `CHK(intDriveEn_q, 1'h0)
      @(posedge clk_sys);
      intRouteActive <= 1'h1;
      ld(ADDR_RESET_KEY);
      wr(RESET_KEY_CODE, 1'h1);
      repeat (SOFT_RST_WAIT_CYC) @(posedge clk_sys);
      ld(ADDR_LVL_UPPER);
      rd(8'h00, 1'h0);
      rd(8'h00, 1'h0);
      complete_run();
   end
endmodule // testbench
bind fprml_regs fprml_regs_asserts fprml_regs_asserts_i (
   .clk_sys        (clk_sys),
   .sys_rst        (sys_rst),
   .addrLoad       (addrLoad),
   .byteRd         (byteRd),
   .byteWr         (byteWr),
   .wrData         (wrData),
   .intRouteActive (intRouteActive),
   .sampleValid    (sampleValid),
   .rdValid_q      (rdValid_q),
   .fifoPop_q      (fifoPop_q),
   .devSoftRst_q   (devSoftRst_q),
   .intDriveEn_q   (intDriveEn_q),
   .motionEvent_q  (motionEvent_q)
);
